// file: hw/pwm_pkg.sv
// Constants and carrier types for the standard pulse-width channel
package pwm_pkg;

  // ----------------------------------------
  // Bus geometry and register byte offsets
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam int NUM_TIMERS = 3;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_DUTY_NEXT = 8'h04;
  localparam logic [7:0] OFF_DUTY_ACTIVE = 8'h08;
  localparam logic [7:0] OFF_TSEL = 8'h0c;
  localparam logic [7:0] OFF_PIN_DIR = 8'h10;
  localparam logic [7:0] OFF_IRQ = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam logic [7:0] OFF_TIMER_BASE = 8'h20;
  localparam logic [7:0] TIMER_STRIDE = 8'h10;
  localparam logic [7:0] OFF_T_LIMIT = 8'h00;
  localparam logic [7:0] OFF_T_CTRL = 8'h04;
  localparam logic [7:0] OFF_T_COUNT = 8'h08;

  // ----------------------------------------
  // Field positions and codes
  // ----------------------------------------
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_DUTY_LOW_LSB = 4;
  localparam int TCTL_PRESCALE_LSB = 0;
  localparam int TCTL_RUN_BIT = 2;
  localparam logic [3:0] MODE_PWM = 4'hc;
  localparam logic [1:0] PS_DIV1 = 2'h0;
  localparam logic [1:0] PS_DIV4 = 2'h1;
  localparam logic [5:0] PRE_LAST_DIV1 = 6'h03;
  localparam logic [5:0] PRE_LAST_DIV4 = 6'h0f;
  localparam logic [5:0] PRE_LAST_DIV16 = 6'h3f;
  localparam int LOW_LSB_DIV1 = 0;
  localparam int LOW_LSB_DIV4 = 2;
  localparam int LOW_LSB_DIV16 = 4;

  // ----------------------------------------
  // Values after reset
  // ----------------------------------------
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_DUTY = 8'h00;
  localparam logic [7:0] RST_LIMIT = 8'hff;
  localparam logic [2:0] RST_TCTL = 3'h0;
  localparam logic [1:0] RST_TSEL = 2'h0;
  localparam logic RST_PIN_DIR = 1'b1;
  localparam logic [2:0] RST_FLAGS = 3'h0;
  localparam logic [5:0] RST_PRE = 6'h00;
  localparam logic [7:0] RST_COUNT = 8'h00;

  // ----------------------------------------
  // Carrier structs
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] limit;
    logic [1:0] prescale;
    logic run;
  } timer_cfg_t;

  typedef struct packed {
    logic [7:0] count;
    logic [1:0] low;
    logic restart;
  } timer_view_t;

endpackage

// file: hw/period_timer.sv
// Shared 8-bit period timer with prescaler and sub-step phase bits
`timescale 1ns/10ps
module period_timer (
  input wire logic pclk,
  input wire logic presetn,
  input pwm_pkg::timer_cfg_t cfg,
  input wire logic sleep,
  input wire logic count_wr,
  input wire logic [7:0] count_wdata,
  output pwm_pkg::timer_view_t view
);
  import pwm_pkg::*;

  typedef struct packed {
    logic [5:0] pre;
    logic [7:0] count;
  } tmr_state_t;

  tmr_state_t st_r;
  tmr_state_t st_nxt;
  logic tick;

  function automatic logic [5:0] pre_last(input logic [1:0] ps);
    if (ps == PS_DIV1) begin
      return PRE_LAST_DIV1;
    end else if (ps == PS_DIV4) begin
      return PRE_LAST_DIV4;
    end
    return PRE_LAST_DIV16;
  endfunction

  // ----------------------------------------
  // Counting
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    // tick every 4, 16 or 64 cycles (phase divide by 1, 4 or 16)
    tick = cfg.run && !sleep && (st_r.pre >= pre_last(cfg.prescale));
    view.restart = tick && (st_r.count == cfg.limit);
    if (count_wr) begin
      st_nxt.count = count_wdata;
      st_nxt.pre = RST_PRE;
    end else if (tick) begin
      st_nxt.pre = RST_PRE;
      if (st_r.count == cfg.limit) begin
        st_nxt.count = RST_COUNT;
      end else begin
        st_nxt.count = st_r.count + 8'h01;
      end
    end else if (cfg.run && !sleep) begin
      st_nxt.pre = st_r.pre + 6'h01;
    end
    view.count = st_r.count;
    if (cfg.prescale == PS_DIV1) begin
      view.low = st_r.pre[LOW_LSB_DIV1 +: 2];
    end else if (cfg.prescale == PS_DIV4) begin
      view.low = st_r.pre[LOW_LSB_DIV4 +: 2];
    end else begin
      view.low = st_r.pre[LOW_LSB_DIV16 +: 2];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '{pre: RST_PRE, count: RST_COUNT};
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule

// file: hw/standard_pwm_channel.sv
// Standard pulse-width channel with APB registers and three period timers
`timescale 1ns/10ps
module standard_pwm_channel (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pwm_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleep,
  output logic channel_output_pin,
  output logic channel_output_pin_oe
);
  import pwm_pkg::*;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] duty_next_high;
    logic [7:0] duty_active_high;
    logic [1:0] low_latch;
    logic [1:0] tsel;
    logic pin_dir;
    logic [NUM_TIMERS-1:0] flags;
    logic [NUM_TIMERS-1:0][7:0] limit;
    logic [NUM_TIMERS-1:0][2:0] tctl;
    logic pin_level;
    logic pin_oe;
    logic rise_pend;
    logic [31:0] prdata;
    logic pslverr;
  } chan_state_t;

  chan_state_t st_r;
  chan_state_t st_nxt;
  timer_cfg_t cfg [NUM_TIMERS];
  timer_view_t view [NUM_TIMERS];
  timer_view_t sv;
  logic [NUM_TIMERS-1:0] cnt_wr;
  logic [NUM_TIMERS-1:0] restarts;
  logic setup;
  logic take_wr;
  logic hit;
  logic pwm_mode;
  logic [9:0] base;
  logic [9:0] duty_act;
  logic [9:0] duty_pend;
  logic [31:0] rd;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] timer_addr(input int idx, input logic [7:0] off);
    return 8'(OFF_TIMER_BASE + 8'(idx) * TIMER_STRIDE + off);
  endfunction

  function automatic int timer_index(input logic [1:0] code);
    if (int'(code) < NUM_TIMERS) begin
      return int'(code);
    end
    return 0;
  endfunction

  function automatic logic is_pwm(input logic [7:0] ctrl);
    return ctrl[CTRL_MODE_LSB +: 4] == MODE_PWM;
  endfunction

  function automatic logic [1:0] duty_low(input logic [7:0] ctrl);
    return ctrl[CTRL_DUTY_LOW_LSB +: 2];
  endfunction

  // ----------------------------------------
  // Shared period timers
  // ----------------------------------------
  for (genvar g = 0; g < NUM_TIMERS; g++) begin : g_tmr
    assign cfg[g].limit = st_r.limit[g];
    assign cfg[g].prescale = st_r.tctl[g][TCTL_PRESCALE_LSB +: 2];
    assign cfg[g].run = st_r.tctl[g][TCTL_RUN_BIT];
    assign restarts[g] = view[g].restart;
    period_timer u_tmr (
      .pclk(pclk),
      .presetn(presetn),
      .cfg(cfg[g]),
      .sleep(sleep),
      .count_wr(cnt_wr[g]),
      .count_wdata(pwdata[7:0]),
      .view(view[g])
    );
  end

  // ----------------------------------------
  // Register file, bus and waveform
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    setup = psel && !penable;
    take_wr = psel && penable && pwrite;
    cnt_wr = '0;
    hit = 1'b0;
    rd = 32'h0000_0000;

    // Read decode
    unique case (paddr)
      OFF_CTRL: begin
        hit = 1'b1;
        rd = {24'h00_0000, st_r.ctrl};
      end
      OFF_DUTY_NEXT: begin
        hit = 1'b1;
        rd = {24'h00_0000, st_r.duty_next_high};
      end
      OFF_DUTY_ACTIVE: begin
        hit = 1'b1;
        rd = {24'h00_0000, st_r.duty_active_high};
      end
      OFF_TSEL: begin
        hit = 1'b1;
        rd = {30'h0000_0000, st_r.tsel};
      end
      OFF_PIN_DIR: begin
        hit = 1'b1;
        rd = {31'h0000_0000, st_r.pin_dir};
      end
      OFF_IRQ: begin
        hit = 1'b1;
        rd = {29'h0000_0000, st_r.flags};
      end
      OFF_STATUS: begin
        hit = 1'b1;
        rd = {28'h000_0000, st_r.low_latch, st_r.pin_oe, st_r.pin_level};
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    for (int i = 0; i < NUM_TIMERS; i++) begin
      if (paddr == timer_addr(i, OFF_T_LIMIT)) begin
        hit = 1'b1;
        rd = {24'h00_0000, st_r.limit[i]};
      end
      if (paddr == timer_addr(i, OFF_T_CTRL)) begin
        hit = 1'b1;
        rd = {29'h0000_0000, st_r.tctl[i]};
      end
      if (paddr == timer_addr(i, OFF_T_COUNT)) begin
        hit = 1'b1;
        rd = {24'h00_0000, view[i].count};
      end
    end

    // Answer prepared in the setup cycle
    if (setup) begin
      st_nxt.prdata = hit ? rd : 32'h0000_0000;
      st_nxt.pslverr = !hit;
    end

    // Software writes
    if (take_wr && hit) begin
      unique case (paddr)
        OFF_CTRL: begin
          st_nxt.ctrl = pwdata[7:0];
        end
        OFF_DUTY_NEXT: begin
          st_nxt.duty_next_high = pwdata[7:0];
        end
        OFF_DUTY_ACTIVE: begin
          if (!is_pwm(st_r.ctrl)) begin
            st_nxt.duty_active_high = pwdata[7:0];
          end
        end
        OFF_TSEL: begin
          st_nxt.tsel = pwdata[1:0];
        end
        OFF_PIN_DIR: begin
          st_nxt.pin_dir = pwdata[0];
        end
        OFF_IRQ: begin
          st_nxt.flags = st_r.flags & ~pwdata[NUM_TIMERS-1:0];
        end
        default: begin
        end
      endcase
      for (int i = 0; i < NUM_TIMERS; i++) begin
        if (paddr == timer_addr(i, OFF_T_LIMIT)) begin
          st_nxt.limit[i] = pwdata[7:0];
        end
        if (paddr == timer_addr(i, OFF_T_CTRL)) begin
          st_nxt.tctl[i] = pwdata[2:0];
        end
        if (paddr == timer_addr(i, OFF_T_COUNT)) begin
          cnt_wr[i] = 1'b1;
        end
      end
    end

    st_nxt.flags = st_nxt.flags | restarts;

    // ----------------------------------------
    // Waveform of the selected timer
    // ----------------------------------------
    sv = view[timer_index(st_r.tsel)];
    pwm_mode = is_pwm(st_r.ctrl);
    base = {sv.count, sv.low};
    duty_act = {st_r.duty_active_high, st_r.low_latch};
    duty_pend = {st_r.duty_next_high, duty_low(st_r.ctrl)};
    if (!pwm_mode) begin
      st_nxt.pin_level = 1'b0;
      st_nxt.rise_pend = 1'b0;
    end else if (!sleep) begin
      if (base == duty_act) begin
        st_nxt.pin_level = 1'b0;
      end
      if (sv.restart) begin
        {st_nxt.duty_active_high, st_nxt.low_latch} = duty_pend;
        // Rise one cycle late, in step with the registered match
        st_nxt.rise_pend = 1'b1;
      end else if (st_r.rise_pend) begin
        st_nxt.pin_level = duty_act != 10'h000;
        st_nxt.rise_pend = 1'b0;
      end
    end

    // drive only when direction is output
    st_nxt.pin_oe = is_pwm(st_nxt.ctrl) && !st_nxt.pin_dir;
  end

  // ----------------------------------------
  // State registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r.ctrl <= RST_CTRL;
      st_r.duty_next_high <= RST_DUTY;
      st_r.duty_active_high <= RST_DUTY;
      st_r.low_latch <= 2'h0;
      st_r.tsel <= RST_TSEL;
      st_r.pin_dir <= RST_PIN_DIR;
      st_r.flags <= RST_FLAGS;
      st_r.limit <= {NUM_TIMERS{RST_LIMIT}};
      st_r.tctl <= {NUM_TIMERS{RST_TCTL}};
      st_r.pin_level <= 1'b0;
      st_r.pin_oe <= 1'b0;
      st_r.rise_pend <= 1'b0;
      st_r.prdata <= 32'h0000_0000;
      st_r.pslverr <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign pready = 1'b1;
  assign prdata = st_r.prdata;
  assign pslverr = st_r.pslverr;
  assign channel_output_pin = st_r.pin_level;
  assign channel_output_pin_oe = st_r.pin_oe;

endmodule

// file: sim/pwm_load.sv
// Load model on the channel pin: pulled-down pad with a pulse meter
`timescale 1ns/10ps
module pwm_load (
  input wire logic pclk,
  input wire logic pin,
  input wire logic oe,
  output logic pad,
  output int high_len,
  output int per_len
);
  int hc = 0;
  int pc = 0;
  logic prev = 1'b0;

  // ----
  // Pad level and pulse meter
  // ----
  // Pull-down wins while the channel does not drive
  assign pad = oe ? pin : 1'b0;
  initial high_len = 0;
  initial per_len = 0;
  always @(posedge pclk) begin
    pc++;
    if (pad && !prev) begin
      per_len = pc;
      pc = 0;
      hc = 0;
    end
    if (pad) begin
      hc++;
    end
    if (!pad && prev) begin
      high_len = hc;
    end
    prev = pad;
  end
endmodule

// file: sim/pwm_checker.sv
// Port assertions for the pulse-width channel
`timescale 1ns/10ps
module pwm_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pwm_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sleep,
  input wire logic channel_output_pin,
  input wire logic channel_output_pin_oe
);
  import pwm_pkg::*;
  logic wr;
  assign wr = psel && penable && pwrite;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----
  // Properties
  // ----
  property p_rst_oe; $rose(presetn) |-> !channel_output_pin_oe; endproperty
  a_rst_oe: assert property (p_rst_oe) else $error("oe high after reset");
  property p_rst_pin; $rose(presetn) |-> !channel_output_pin; endproperty
  a_rst_pin: assert property (p_rst_pin) else $error("pin high after reset");
  property p_release;
    wr && paddr == OFF_CTRL && pwdata[7:0] == 8'h00 |-> ##2 !channel_output_pin_oe;
  endproperty
  a_release: assert property (p_release) else $error("pin not released");
  property p_dir_in; wr && paddr == OFF_PIN_DIR && pwdata[0] |-> ##2 !channel_output_pin_oe;
  endproperty
  a_dir_in: assert property (p_dir_in) else $error("oe high while input");
  property p_mode;
    wr && paddr == OFF_CTRL && pwdata[3:0] != MODE_PWM |-> ##2 !channel_output_pin_oe
      && !channel_output_pin;
  endproperty
  a_mode: assert property (p_mode) else $error("drive in non pwm mode");
  property p_sleep_pin; sleep && !wr && !$past(wr) |=> $stable(channel_output_pin); endproperty
  a_sleep_pin: assert property (p_sleep_pin) else $error("pin moved in sleep");
  property p_sleep_oe; sleep && !wr && !$past(wr) |=> $stable(channel_output_pin_oe);
  endproperty
  a_sleep_oe: assert property (p_sleep_oe) else $error("oe moved in sleep");
  property p_mapped; psel && penable && paddr == OFF_DUTY_NEXT |-> pready && !pslverr;
  endproperty
  a_mapped: assert property (p_mapped) else $error("duty access refused");
  c_rise: cover property ($rose(channel_output_pin));
  c_sleep_hi: cover property (sleep && channel_output_pin);
  c_err: cover property (pslverr);
endmodule

bind standard_pwm_channel pwm_checker chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .sleep, .channel_output_pin, .channel_output_pin_oe);

// file: sim/tb.sv
// Self-checking bench for the pulse-width channel
`timescale 1ns/10ps
module tb;
  import pwm_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sleep = 0;
  logic [7:0] paddr = 8'h00, ta;
  logic [31:0] pwdata = 32'h0, prdata, last_rd;
  logic pready, pslverr, pin, oe, pad;
  logic [9:0] d;
  int high_len, per_len, ps, h, miscompares = 0, compares = 0, cyc = 0, seed = 32'h8a66671b;
  logic [33:0] expq[$];

  initial forever #5 pclk = ~pclk;
  standard_pwm_channel uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .sleep, .channel_output_pin(pin), .channel_output_pin_oe(oe));
  pwm_load load (.pclk, .pin, .oe, .pad, .high_len, .per_len);

  // ----
  // Tasks
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v,
    input logic [33:0] e);
    if (!w) expq.push_back(e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    apb(1'b1, a, v, 34'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic c = 1,
    input logic er = 0);
    apb(1'b0, a, 32'h0, {c, er, x});
  endtask

  // ----
  // Read monitor and timeout
  // ----
  always @(posedge pclk) begin
    logic [33:0] e;
    cyc++;
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      e = expq.pop_front();
      last_rd = prdata;
      if (e[33]) begin
        chk(prdata, e[31:0]);
        chk({31'h0, pslverr}, {31'h0, e[32]});
      end
    end
    if (cyc == 20000) begin
      miscompares++;
      end_of_test();
    end
  end

  // ----
  // Scenarios
  // ----
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(OFF_CTRL, 0);
    rd(OFF_DUTY_NEXT, 0);
    rd(OFF_PIN_DIR, 1);
    rd(OFF_TIMER_BASE, 32'hff);
    rd(8'hfc, 0, 1, 1);
    for (int i = 0; i < 3; i++) begin
      ta = 8'(OFF_TIMER_BASE + TIMER_STRIDE * i);
      d = 10'(1 + {$random(seed)} % 15);
      ps = 1 << (2 * i);
      wr(OFF_PIN_DIR, 1);
      wr(OFF_TSEL, i);
      wr(ta + OFF_T_LIMIT, 3);
      wr(OFF_CTRL, {d[1:0], MODE_PWM});
      wr(OFF_DUTY_NEXT, d[9:2]);
      wr(OFF_IRQ, 1 << i);
      wr(ta + OFF_T_CTRL, 4 | i);
      last_rd = 0;
      for (int k = 0; k < 200 && !last_rd[i]; k++) rd(OFF_IRQ, 0, 0);
      chk(last_rd[i], 1);
      wr(OFF_PIN_DIR, 0);
      repeat (48 * ps) @(posedge pclk);
      chk(per_len, 16 * ps);
      chk(high_len, d * ps);
      rd(OFF_DUTY_ACTIVE, d[9:2]);
      wr(OFF_DUTY_ACTIVE, 8'h55);
      rd(OFF_DUTY_ACTIVE, d[9:2]);
    end
    for (int k = 0; k < 2; k++) begin
      wr(OFF_CTRL, {k ? 2'b11 : 2'b00, MODE_PWM});
      wr(OFF_DUTY_NEXT, k ? 8'hff : 8'h00);
      repeat (512) @(posedge pclk);
      h = 0;
      repeat (256) @(posedge pclk) h += pad;
      chk(h, k * 256);
    end
    sleep <= 1'b1;
    rd(ta + OFF_T_COUNT, 0, 0);
    repeat (100) @(posedge pclk);
    rd(ta + OFF_T_COUNT, last_rd);
    rd(OFF_STATUS, 32'h0000_000f);
    wr(ta + OFF_T_COUNT, 32'h0000_0002);
    rd(ta + OFF_T_COUNT, 32'h0000_0002);
    sleep <= 1'b0;
    wr(OFF_CTRL, 0);
    chk(oe, 0);
    wr(OFF_CTRL, MODE_PWM);
    chk(oe, 1);
    wr(OFF_CTRL, 8'h03);
    @(posedge pclk) chk({oe, pin}, 2'b00);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({oe, pin}, 2'b00);
    rd(OFF_PIN_DIR, 1);
    rd(OFF_CTRL, 0);
    end_of_test();
  end
endmodule
